// File: core/cluster_ctrl_l3_counters.sv
// cluster extended control, revision id and L3 hit/miss counter bank,
// with non-cacheable routing and outstanding-write limiting
// assumes system-register requests and L3 lookup results are synchronous to clk
//
// Behaviour
// R01: routing bit 0 sends NC and device to if0
// R02: ACE, bit 0: NC plus device writes cap 15; cacheable write completions also decrement the count
// R03: bit 1, dual: NC interleaves; device to if0
// R04: ACE, bit 1: only device writes cap 15
// R05: once routing bit set, later writes ignored
// R06: extended control decoded at c15, c3, 4
// R07: revision reads contents, writes discarded
// R08: major [7:4], minor [3:0], upper zeros
// R09: revision decoded at c15, c3, 1
// R10: hit counter 32 bits, saturates at max
// R11: software write loads the hit counter
// R12: hit counter resets to zero
// R13: secure lookups uncounted unless secure-count enable
// R14: hit counter decoded at c15, c4, 5
// R15: separate read/write miss counter exists
// R16: miss counter 32-bit, saturating, loadable, zero reset
// R17: count one per lookup; write beats increment
`timescale 1ns/1ps
`default_nettype none
module cluster_ctrl_l3_counters
  import cluster_regs_pkg::*;
#(
  parameter logic [3:0] REV_MAJOR = 4'h2, // arbitrary value
  parameter logic [3:0] REV_MINOR = 4'h3, // arbitrary value
  parameter bit ACE_CONFIG = 1'b1,
  parameter bit DUAL_MASTER = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // system-register access
  input wire sysreg_req_t sysreg_req,
  output logic [31:0] sysreg_rdata,
  output logic sysreg_rvalid,
  // performance monitor control
  input wire logic secure_count_enable,
  // L3 lookup results
  input wire logic l3_lookup_valid,
  input wire logic l3_lookup_hit,
  input wire logic l3_lookup_secure,
  // transaction routing
  input wire txn_req_t txn_in,
  output logic txn_ready,
  output logic txn_valid_if0,
  output logic txn_valid_if1,
  // write completions
  input wire logic wr_done,
  input wire logic wr_done_device,
  // status
  output logic nc_route_all
);

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire base_hit = sysreg_req.valid && (sysreg_req.crn == SYSREG_CRN);
  wire sel_ctrl = base_hit && sysreg_req.crm == CRM_CTRL
                  && sysreg_req.op2 == OP2_EXT_CTRL; // see R06
  wire sel_rev = base_hit && sysreg_req.crm == CRM_CTRL
                 && sysreg_req.op2 == OP2_REV_ID; // see R09
  wire sel_hit = base_hit && sysreg_req.crm == CRM_CNT
                 && sysreg_req.op2 == OP2_HIT; // see R14
  wire sel_miss = base_hit && sysreg_req.crm == CRM_CNT
                  && sysreg_req.op2 == OP2_MISS; // see R15
  wire wr_ctrl = sel_ctrl && sysreg_req.write;
  wire wr_hit = sel_hit && sysreg_req.write;
  wire wr_miss = sel_miss && sysreg_req.write;
  // revision writes have no decode path at all; see R07

  // ----------------------------------------
  // routing control bit
  // ----------------------------------------
  logic nc_route_q;
  logic nc_route_d;

  // sticky: only a 0 may be overwritten; see R05
  assign nc_route_d = nc_route_q ? 1'b1 :
                      wr_ctrl ? sysreg_req.wdata[NC_ROUTE_BIT] : 1'b0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nc_route_q <= NC_ROUTE_RESET;
    end else begin
      nc_route_q <= nc_route_d;
    end
  end

  assign nc_route_all = nc_route_q;

  // ----------------------------------------
  // L3 counters
  // ----------------------------------------
  logic [31:0] hit_count;
  logic [31:0] miss_count;
  // secure lookups drop out unless enabled; see R13
  wire lookup_ok = l3_lookup_valid && (secure_count_enable || !l3_lookup_secure);
  wire hit_inc = lookup_ok && l3_lookup_hit; // see R17
  wire miss_inc = lookup_ok && !l3_lookup_hit;

  sat_counter u_hit_counter (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(wr_hit), // see R11
    .load_value(sysreg_req.wdata),
    .inc(hit_inc),
    .count(hit_count)
  );

  sat_counter u_miss_counter (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(wr_miss), // see R16
    .load_value(sysreg_req.wdata),
    .inc(miss_inc),
    .count(miss_count)
  );

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  wire rd = sysreg_req.valid && !sysreg_req.write;
  wire [31:0] rev_word = {24'h00_0000, REV_MAJOR, REV_MINOR}; // see R08
  wire [31:0] ctrl_word = {31'h0000_0000, nc_route_q};

  // unmapped encodings read as zero
  assign rdata_d = sel_ctrl ? ctrl_word :
                   sel_rev ? rev_word : // see R07
                   sel_hit ? hit_count :
                   sel_miss ? miss_count : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rd ? rdata_d : rdata_q;
      rvalid_q <= rd;
    end
  end

  assign sysreg_rdata = rdata_q;
  assign sysreg_rvalid = rvalid_q;

  // ----------------------------------------
  // outstanding write tracking
  // ----------------------------------------
  // limited count covers device writes, plus NC writes while bit is 0
  logic [3:0] lim_q;
  logic [3:0] lim_d;
  // an NC write issued while the bit was 0 stays in the count for good if it completes
  // after the bit rises; accepted because the bit is set only at boot
  wire txn_counted = txn_in.device || (txn_in.non_cacheable && !nc_route_q);
  wire is_limited = ACE_CONFIG && txn_in.write && txn_counted; // see R02
  wire at_limit = (lim_q == WRITE_LIMIT); // see R04
  wire done_limited = ACE_CONFIG && wr_done
                      && (wr_done_device || !nc_route_q);

  assign txn_ready = !(is_limited && at_limit);
  wire issue_lim = txn_in.valid && txn_ready && is_limited;

  assign lim_d = (issue_lim && !done_limited) ? lim_q + 4'h1 :
                 (!issue_lim && done_limited && lim_q != 4'h0) ? lim_q - 4'h1 :
                 lim_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lim_q <= 4'h0;
    end else begin
      lim_q <= lim_d;
    end
  end

  // ----------------------------------------
  // interface selection
  // ----------------------------------------
  // device always if0; NC follows cacheable interleave only once bit is 1
  wire to_if1 = DUAL_MASTER && !txn_in.device
                && (!txn_in.non_cacheable || nc_route_q) // see R01 see R03
                && txn_in.pref_if;

  assign txn_valid_if0 = txn_in.valid && txn_ready && !to_if1;
  assign txn_valid_if1 = txn_in.valid && txn_ready && to_if1;

endmodule
`default_nettype wire

// File: core/cluster_regs_pkg.sv
// package for the cluster control, revision and L3 counter register bank
// assumes a single system-register access port from the cluster cores
package cluster_regs_pkg;

  // ----------------------------------------
  // system-register encodings (crn, crm, op2)
  // ----------------------------------------
  localparam logic [3:0] SYSREG_CRN = 4'hf;
  localparam logic [3:0] CRM_CTRL = 4'h3;
  localparam logic [3:0] CRM_CNT = 4'h4;
  localparam logic [2:0] OP2_EXT_CTRL = 3'h4;
  localparam logic [2:0] OP2_REV_ID = 3'h1;
  localparam logic [2:0] OP2_HIT = 3'h5;
  localparam logic [2:0] OP2_MISS = 3'h6;

  // ----------------------------------------
  // fields, reset values and limits
  // ----------------------------------------
  localparam int NC_ROUTE_BIT = 0;
  localparam logic NC_ROUTE_RESET = 1'b0;
  localparam int REV_MAJOR_LSB = 4;
  localparam int REV_MINOR_LSB = 0;
  localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNTER_MAX = 32'hffff_ffff;
  localparam logic [3:0] WRITE_LIMIT = 4'hf;

  // system-register access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [31:0] wdata;
  } sysreg_req_t;

  // one outgoing transaction to be routed
  typedef struct packed {
    logic valid;
    logic write;
    logic device;
    logic non_cacheable;
    logic pref_if;
  } txn_req_t;

endpackage

// File: core/sat_counter.sv
// saturating 32-bit event counter with software load
// assumes increment qualification is done by the instantiating logic
`timescale 1ns/1ps
`default_nettype none
module sat_counter
  import cluster_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic load,
  input wire logic [31:0] load_value,
  input wire logic inc,
  // state
  output logic [31:0] count
);

  logic [31:0] count_q;
  logic [31:0] count_d;
  wire at_max = (count_q == COUNTER_MAX);

  // write wins over an increment in the same cycle; see R17
  assign count_d = load ? load_value :
                   (inc && !at_max) ? count_q + 32'h0000_0001 : count_q; // see R10

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= COUNTER_RESET; // see R12
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule
`default_nettype wire

// File: tb/cluster_ctrl_l3_counters_sva.sv
// port checker for the cluster register bank
// assumes it is bound into cluster_ctrl_l3_counters
`timescale 1ns/1ps
`default_nettype none
module cluster_ctrl_l3_counters_sva
  import cluster_regs_pkg::*;
#(
  parameter logic [3:0] REV_MAJOR = 4'h2,
  parameter logic [3:0] REV_MINOR = 4'h3
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // watched ports
  input wire sysreg_req_t sysreg_req,
  input wire logic [31:0] sysreg_rdata,
  input wire logic sysreg_rvalid,
  input wire txn_req_t txn_in,
  input wire logic txn_ready,
  input wire logic txn_valid_if0,
  input wire logic txn_valid_if1,
  input wire logic nc_route_all
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic rd = sysreg_req.valid && !sysreg_req.write && sysreg_req.crn == SYSREG_CRN;
  wire logic nc = txn_in.valid && txn_in.non_cacheable && !txn_in.device;
  property p_rv; sysreg_req.valid && !sysreg_req.write |=> sysreg_rvalid; endproperty
  property p_rev; rd && sysreg_req.crm == CRM_CTRL && sysreg_req.op2 == OP2_REV_ID
    |=> sysreg_rdata == {24'h0, REV_MAJOR, REV_MINOR}; endproperty
  property p_ctl; rd && sysreg_req.crm == CRM_CTRL && sysreg_req.op2 == OP2_EXT_CTRL
    |=> sysreg_rdata == {31'h0, $past(nc_route_all)}; endproperty
  property p_stk; nc_route_all |=> nc_route_all [*3]; endproperty
  property p_dev; txn_in.valid && txn_in.device |-> !txn_valid_if1; endproperty
  property p_nc0; !nc_route_all && nc |-> !txn_valid_if1; endproperty
  property p_nc1; nc_route_all && nc && txn_ready
    |-> txn_valid_if1 == txn_in.pref_if && txn_valid_if0 == !txn_in.pref_if; endproperty
  property p_lim; nc_route_all && nc |-> txn_ready; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  a_rev: assert property (p_rev) else $error("revision value wrong");
  a_ctl: assert property (p_ctl) else $error("control readback wrong");
  a_stk: assert property (p_stk) else $error("routing bit cleared");
  a_dev: assert property (p_dev) else $error("device txn off if0");
  a_nc0: assert property (p_nc0) else $error("nc txn off if0");
  a_nc1: assert property (p_nc1) else $error("nc not interleaved");
  a_lim: assert property (p_lim) else $error("nc write capped");
  c_cap: cover property (!txn_ready);
  c_set: cover property ($rose(nc_route_all));
  c_nc1: cover property (nc_route_all && txn_valid_if1);
endmodule
bind cluster_ctrl_l3_counters cluster_ctrl_l3_counters_sva
  #(.REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR)) u_sva (.clk, .sys_rst, .sysreg_req,
  .sysreg_rdata, .sysreg_rvalid, .txn_in, .txn_ready, .txn_valid_if0, .txn_valid_if1,
  .nc_route_all);
`default_nettype wire

// File: tb/cluster_ctrl_l3_counters_tb.sv
// self-checking bench for the cluster register bank
// assumes interconnect_model as far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module cluster_ctrl_l3_counters_tb
  import cluster_regs_pkg::*;
;
  logic clk, sys_rst, secure_count_enable, l3_lookup_valid, l3_lookup_hit, l3_lookup_secure;
  logic sysreg_rvalid, txn_ready, txn_valid_if0, txn_valid_if1, wr_done, wr_done_device;
  logic nc_route_all, idle, stall;
  logic [31:0] sysreg_rdata, e, exp_hit, exp_miss, exp_q[$];
  sysreg_req_t sysreg_req;
  txn_req_t txn_in;
  int mismatches, total_checks, n, seed = 39;
  cluster_ctrl_l3_counters #(.REV_MAJOR(4'h5), .REV_MINOR(4'ha)) DUT (.clk, .sys_rst,
    .sysreg_req, .sysreg_rdata, .sysreg_rvalid, .secure_count_enable, .l3_lookup_valid,
    .l3_lookup_hit, .l3_lookup_secure, .txn_in, .txn_ready, .txn_valid_if0, .txn_valid_if1,
    .wr_done, .wr_done_device, .nc_route_all);
  interconnect_model u_ic (.clk, .sys_rst, .stall, .txn_in, .txn_valid_if0, .txn_valid_if1,
    .wr_done, .wr_done_device, .idle);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (sysreg_rvalid === 1'b1) begin
    e = exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead_beef;
    `CHK("rdata", e, sysreg_rdata)
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic acc(logic w, logic [3:0] m, logic [2:0] o, logic [31:0] d);
    @(posedge clk);
    sysreg_req <= '{1'b1, w, SYSREG_CRN, m, o, d};
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    sysreg_req <= '0;
  endtask
  task automatic look(int k);
    logic [1:0] r;
    repeat (k) begin
      @(posedge clk);
      r = 2'($random(seed));
      l3_lookup_valid <= 1'b1;
      l3_lookup_hit <= r[0];
      l3_lookup_secure <= r[1];
      if (!r[1] || secure_count_enable) begin
        if (r[0]) exp_hit = exp_hit == COUNTER_MAX ? exp_hit : exp_hit + 1;
        else exp_miss++;
      end
    end
    @(posedge clk);
    l3_lookup_valid <= 1'b0;
  endtask
  task automatic burst(txn_req_t t, int x);
    n = 0;
    @(posedge clk);
    txn_in <= t;
    repeat (20) begin
      @(posedge clk);
      if (txn_valid_if0 === 1'b1 || txn_valid_if1 === 1'b1) n++;
    end
    txn_in <= '0;
    `CHK("accepted", x, n)
  endtask
  task automatic drain();
    stall <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (idle !== 1'b1 && n < 50);
    if (n >= 50) begin mismatches++; final_report(); end
    stall <= 1'b1;
  endtask
  initial begin #200000; mismatches++; final_report(); end
  initial begin
    {sys_rst, stall, secure_count_enable} = 3'b110;
    {l3_lookup_valid, l3_lookup_hit, l3_lookup_secure} = 3'b000;
    sysreg_req = '0;
    txn_in = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    acc(0, CRM_CNT, OP2_HIT, 32'h0);
    acc(0, CRM_CNT, OP2_MISS, 32'h0);
    acc(0, CRM_CTRL, OP2_EXT_CTRL, 32'h0);
    acc(1, CRM_CTRL, OP2_REV_ID, 32'hffff_ffff);
    acc(0, CRM_CTRL, OP2_REV_ID, 32'h0000_005a);
    acc(0, 4'h9, 3'h7, 32'h0);
    exp_hit = 32'hffff_fff0;
    exp_miss = 32'h0000_0007;
    acc(1, CRM_CNT, OP2_HIT, exp_hit);
    acc(1, CRM_CNT, OP2_MISS, exp_miss);
    look(40);
    secure_count_enable <= 1'b1;
    look(40);
    acc(0, CRM_CNT, OP2_HIT, exp_hit);
    acc(0, CRM_CNT, OP2_MISS, exp_miss);
    burst('{1'b1, 1'b1, 1'b1, 1'b0, 1'b1}, 15);
    drain();
    burst('{1'b1, 1'b1, 1'b0, 1'b1, 1'b1}, 15);
    drain();
    acc(1, CRM_CTRL, OP2_EXT_CTRL, 32'h1);
    acc(1, CRM_CTRL, OP2_EXT_CTRL, 32'h0);
    acc(0, CRM_CTRL, OP2_EXT_CTRL, 32'h1);
    burst('{1'b1, 1'b1, 1'b0, 1'b1, 1'b1}, 20);
    burst('{1'b1, 1'b1, 1'b1, 1'b0, 1'b1}, 15);
    // a hit lands in the same cycle as a software load: the load must win
    @(posedge clk);
    sysreg_req <= '{1'b1, 1'b1, SYSREG_CRN, CRM_CNT, OP2_HIT, 32'h0000_1234};
    {l3_lookup_valid, l3_lookup_hit, l3_lookup_secure} <= 3'b110;
    @(posedge clk);
    sysreg_req <= '0;
    l3_lookup_valid <= 1'b0;
    acc(0, CRM_CNT, OP2_HIT, 32'h0000_1234);
    repeat (5) @(posedge clk);
    `CHK("reads left", 0, exp_q.size())
    final_report();
  end
endmodule
`default_nettype wire

// File: tb/interconnect_model.sv
// interconnect stand-in: completes accepted writes in order
// assumes the bank's clk and sys_rst; stall holds completions back
`timescale 1ns/1ps
`default_nettype none
module interconnect_model
  import cluster_regs_pkg::*;
(
  // clock, reset, control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic stall,
  // bank side
  input wire txn_req_t txn_in,
  input wire logic txn_valid_if0,
  input wire logic txn_valid_if1,
  output logic wr_done,
  output logic wr_done_device,
  output logic idle
);
  bit pend_q[$];
  // one completion a cycle, flagged by kind
  always @(posedge clk) begin
    wr_done <= 1'b0;
    wr_done_device <= 1'b0;
    if (sys_rst) pend_q.delete();
    else if (!stall && pend_q.size() > 0) begin
      wr_done <= 1'b1;
      wr_done_device <= pend_q.pop_front();
    end
    if (!sys_rst && (txn_valid_if0 || txn_valid_if1) && txn_in.write) begin
      pend_q.push_back(txn_in.device);
    end
    idle <= pend_q.size() == 0;
  end
endmodule
`default_nettype wire
